// [rtl/stt_pkg.sv]
`default_nettype none
package stt_pkg;

  // ==========================================================
  // opcodes
  localparam logic [9:0] OP_SKIP_ON_PIN_LEVEL = 10'h03A;
  localparam logic [9:0] OP_SKIP_ON_EXT_IRQ_FLAG = 10'h038;

  // ==========================================================
  // field positions and reset values
  localparam int PIN_POLARITY_BIT = 2;
  localparam int EXT_IRQ_MASK_BIT = 0;
  localparam logic RST_SKIP = 1'b0;
  localparam logic RST_FLAG = 1'b0;

  // ==========================================================
  // one fetched word with its valid strobe
  typedef struct packed {
    logic valid;
    logic [9:0] opcode;
  } stt_fetch_t;

endpackage : stt_pkg
`default_nettype wire

// [rtl/stt_skip_test.sv]
`timescale 1ns/1ps
`default_nettype none

module stt_skip_test
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // fetch
  input wire stt_pkg::stt_fetch_t fetch_in,
  // control registers
  input wire logic [3:0] irq_control_reg_a_in,
  input wire logic [3:0] irq_control_reg_b_in,
  // interrupt pin and flag
  input wire logic irq_pin_in,
  input wire logic ext_irq_set_in,
  // results
  output logic skip_out,
  output logic ext_irq_request_flag_out,
  output logic exec_valid_out,
  output logic [9:0] exec_opcode_out
);

  // ==========================================================
  // pin synchroniser
  logic [2:0] pin_sync_reg;
  logic [2:0] pin_sync_next;
  logic pin_level_reg;
  logic pin_level_next;

  always_comb
  begin
    pin_sync_next = {pin_sync_reg[1:0], irq_pin_in};
    pin_level_next = pin_level_reg;
    // a change counts only once stages two and three agree
    if (pin_sync_reg[2] == pin_sync_reg[1])
    begin
      pin_level_next = pin_sync_reg[2];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      pin_sync_reg <= 3'h0;
      pin_level_reg <= 1'b0;
    end
    else
    begin
      pin_sync_reg <= pin_sync_next;
      pin_level_reg <= pin_level_next;
    end
  end

  // ==========================================================
  // decode and skip
  logic skip_reg;
  logic skip_next;
  logic flag_reg;
  logic flag_next;
  logic exec_valid_reg;
  logic exec_valid_next;
  logic [9:0] exec_opcode_reg;
  logic [9:0] exec_opcode_next;
  logic live;
  logic polarity;
  logic mask;

  always_comb
  begin
    // a skipped word is consumed here and never executes
    live = fetch_in.valid && !skip_reg;
    polarity = irq_control_reg_a_in[stt_pkg::PIN_POLARITY_BIT];
    mask = irq_control_reg_b_in[stt_pkg::EXT_IRQ_MASK_BIT];
    skip_next = skip_reg;
    flag_next = flag_reg;
    exec_valid_next = live;
    exec_opcode_next = fetch_in.opcode;
    if (fetch_in.valid)
    begin
      skip_next = 1'b0;
    end
    if (live && fetch_in.opcode == stt_pkg::OP_SKIP_ON_PIN_LEVEL)
    begin
      skip_next = polarity ? pin_level_reg : !pin_level_reg;
    end
    if (live && fetch_in.opcode == stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG
        && !mask)
    begin
      skip_next = flag_reg;
      flag_next = 1'b0;
    end
    // a new event wins over a clear in the same cycle
    if (ext_irq_set_in)
    begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      skip_reg <= stt_pkg::RST_SKIP;
      flag_reg <= stt_pkg::RST_FLAG;
      exec_valid_reg <= 1'b0;
      exec_opcode_reg <= 10'h000;
    end
    else
    begin
      skip_reg <= skip_next;
      flag_reg <= flag_next;
      exec_valid_reg <= exec_valid_next;
      exec_opcode_reg <= exec_opcode_next;
    end
  end

  assign skip_out = skip_reg;
  assign ext_irq_request_flag_out = flag_reg;
  assign exec_valid_out = exec_valid_reg;
  assign exec_opcode_out = exec_opcode_reg;

  // ==========================================================
  // check sequences
  sequence pin_test_s;
    fetch_in.valid && !skip_reg
      && fetch_in.opcode == stt_pkg::OP_SKIP_ON_PIN_LEVEL;
  endsequence

  sequence flag_test_s;
    fetch_in.valid && !skip_reg
      && fetch_in.opcode == stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG;
  endsequence

  // a fetched word that lands while a skip is pending
  sequence dropped_s;
    skip_reg && fetch_in.valid;
  endsequence

  // ==========================================================
  // checks: decode and skip
  a_pin_skip_low: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    pin_test_s and (!polarity && !pin_level_reg) |=> skip_reg)
    else $error("pin low test did not skip");

  a_pin_skip_high: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    pin_test_s and (polarity && pin_level_reg) |=> skip_reg)
    else $error("pin high test did not skip");

  a_pin_no_skip: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    pin_test_s and (polarity != pin_level_reg) |=> !skip_reg)
    else $error("pin test skipped on mismatch");

  a_other_no_skip: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    fetch_in.valid && fetch_in.opcode != stt_pkg::OP_SKIP_ON_PIN_LEVEL
      && fetch_in.opcode != stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG |=> !skip_reg)
    else $error("unrelated word raised a skip");

  a_mask_nop: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    flag_test_s and mask and !ext_irq_set_in
      |=> !skip_reg && $stable(flag_reg))
    else $error("masked flag test was not a no-op");

  a_flag_clear_skip: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    flag_test_s and !mask and !ext_irq_set_in
      |=> skip_reg == $past(flag_reg) && !flag_reg)
    else $error("flag test wrong");

  a_set_wins: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    ext_irq_set_in |=> flag_reg)
    else $error("flag set lost");

  a_skip_blocks_exec: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    dropped_s |=> !exec_valid_reg && !skip_reg)
    else $error("skipped word executed");

  a_skip_holds: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    skip_reg && !fetch_in.valid |=> skip_reg)
    else $error("pending skip lost without a fetch");

  a_flag_held: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    dropped_s and !ext_irq_set_in |=> $stable(flag_reg))
    else $error("skipped word touched the flag");

  a_exec_passes: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    fetch_in.valid && !skip_reg |=> exec_valid_reg
      && exec_opcode_reg == $past(fetch_in.opcode))
    else $error("live word not passed");

  a_idle_no_exec: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    !fetch_in.valid |=> !exec_valid_reg)
    else $error("word executed without a fetch");

  // ==========================================================
  // checks: pin filter
  // two stages must agree: one cycle more latency, no one-cycle glitch is taken
  a_sync_filter: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    pin_sync_reg[2] != pin_sync_reg[1] |=> $stable(pin_level_reg))
    else $error("pin level moved on disagreeing stages");

  a_level_follows: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    pin_sync_reg[2] == pin_sync_reg[1]
      |=> pin_level_reg == $past(pin_sync_reg[2]))
    else $error("pin level did not follow agreeing stages");

endmodule : stt_skip_test

`default_nettype wire

// [dv/stt_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: the source driving the interrupt input pin
module stt_pin_model
(
  // clock
  input wire logic clk_sys_in,
  // pin
  output var logic irq_pin_out
);
  // changes just after an edge, as a real pin is unrelated to clk
  task automatic drive(input logic lvl);
    @(posedge clk_sys_in);
    #1 irq_pin_out = lvl;
  endtask : drive
  initial irq_pin_out = 1'b1;
endmodule : stt_pin_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // stimulus and results
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  stt_pkg::stt_fetch_t fetch = '0;
  logic [3:0] reg_a = 4'h0;
  logic [3:0] reg_b = 4'h0;
  logic set = 1'b0;
  logic pin, skip, flag, ev;
  logic [9:0] eop;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  stt_pin_model u_pin (.clk_sys_in(clk_sys_in), .irq_pin_out(pin));
  stt_skip_test u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .fetch_in(fetch), .irq_control_reg_a_in(reg_a),
    .irq_control_reg_b_in(reg_b), .irq_pin_in(pin),
    .ext_irq_set_in(set), .skip_out(skip),
    .ext_irq_request_flag_out(flag), .exec_valid_out(ev),
    .exec_opcode_out(eop));
  // ==========================================================
  // checking and closing
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      final_report();
    end
  end
  task automatic word(input logic [9:0] op);
    @(posedge clk_sys_in);
    #1 fetch = {1'b1, op};
    @(posedge clk_sys_in);
    #1 fetch = '0;
  endtask : word
  // a test word, then a follower that must be dropped on a skip
  task automatic run(input logic [9:0] op, input logic sk);
    word(op);
    check({9'h0, skip}, {9'h0, sk});
    check({9'h0, ev}, 10'h001);
    check(eop, op);
    word(10'h155);
    check({9'h0, ev}, {9'h0, ~sk});
    check({9'h0, skip}, 10'h000);
  endtask : run
  // other bits of reg a oppose bit 2 so a wrong bit is seen
  task automatic pin_case(input logic pol, input logic lvl);
    reg_a = pol ? 4'h4 : 4'hB;
    u_pin.drive(lvl);
    repeat (6) @(posedge clk_sys_in);
    run(stt_pkg::OP_SKIP_ON_PIN_LEVEL, lvl == pol);
  endtask : pin_case
  task automatic raise_flag();
    @(posedge clk_sys_in);
    #1 set = 1'b1;
    @(posedge clk_sys_in);
    #1 set = 1'b0;
  endtask : raise_flag
  // flag test and a new event in one cycle: the event wins
  task automatic set_wins();
    @(posedge clk_sys_in);
    #1 fetch = {1'b1, stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG};
    set = 1'b1;
    @(posedge clk_sys_in);
    #1 fetch = '0;
    set = 1'b0;
    check({9'h0, skip}, 10'h000);
    check({9'h0, flag}, 10'h001);
  endtask : set_wins
  // a flag test that is skipped must leave the flag alone
  task automatic skipped_flag_test();
    reg_a = 4'h4;
    word(stt_pkg::OP_SKIP_ON_PIN_LEVEL);
    check({9'h0, skip}, 10'h001);
    word(stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG);
    check({9'h0, ev}, 10'h000);
    check({9'h0, flag}, 10'h001);
  endtask : skipped_flag_test
  // a second reset mid-run, with a skip and the flag pending
  task automatic reset_case();
    raise_flag();
    word(stt_pkg::OP_SKIP_ON_PIN_LEVEL);
    check({8'h00, skip, flag}, 10'h003);
    srst_in = 1'b1;
    @(posedge clk_sys_in);
    #1 check({7'h00, skip, flag, ev}, 10'h000);
    check(eop, 10'h000);
    srst_in = 1'b0;
    run(stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG, 1'b0);
  endtask : reset_case
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    #1 srst_in = 1'b0;
    for (int i = 0; i < 4; i++)
      pin_case(i[1], i[0]);
    reg_b = 4'hF;
    raise_flag();
    run(stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG, 1'b0);
    check({9'h0, flag}, 10'h001);
    reg_b = 4'hE;
    run(stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG, 1'b1);
    check({9'h0, flag}, 10'h000);
    run(stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG, 1'b0);
    set_wins();
    skipped_flag_test();
    run(stt_pkg::OP_SKIP_ON_EXT_IRQ_FLAG, 1'b1);
    reset_case();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
